// ===== pkg/seq_io_cfg.svh
`ifndef SEQ_IO_CFG_SVH
`define SEQ_IO_CFG_SVH

// Register byte offsets on the Avalon-MM slave
`define OFS_WAIT_CYCLES 8'h00
`define OFS_BUS_WRITE 8'h04
`define OFS_BUS_READ 8'h08
`define OFS_BUS_LATCHED 8'h0c
`define OFS_TRIG_OUT 8'h10
`define OFS_TRIG_IN1 8'h14
`define OFS_TRIG_IN2 8'h18
`define OFS_STROBE_CFG 8'h1c
`define OFS_WAIT_CMD 8'h20
`define OFS_STATUS 8'h24
`define OFS_LFSR_POLY 8'h28
`define OFS_LFSR_STATE 8'h2c
`define OFS_MARKER_CFG 8'h30
`define OFS_BUS_DIR 8'h34

// Strobe configuration fields
`define STROBE_IDX_LSB 0
`define STROBE_IDX_MSB 4
`define STROBE_SLOPE_BIT 5

// Wait command bits
`define CMD_BUS_TRIG_BIT 0
`define CMD_TRIG_IN1_BIT 1
`define CMD_TRIG_IN2_BIT 2
`define CMD_PLAYBACK_BIT 3

// Marker configuration fields
`define MARKER_SEL_LSB 0
`define MARKER_SEL_MSB 1
`define MARKER_EN_BIT 2

// Reset values
`define RST_LFSR_POLY 32'h0009_0000
`define RST_LFSR_STATE 32'h0000_0001
`define RST_MARKER_CFG 3'h1
`define RST_STROBE_CFG 6'h00

// Timing: sequencer cycle, wait overhead and minimum, bus pacing
`define CLK_PERIOD_NS 20
`define SEQ_CYCLE_NS 4
`define WAIT_OVERHEAD 2
`define WAIT_MIN 3
`define BUS_RATE_MHZ 50
`define SEQ_CYCLE_CLKS \
  (((`SEQ_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
   ((`SEQ_CYCLE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define BUS_PACE_CLKS \
  (((1000 / `BUS_RATE_MHZ) / `CLK_PERIOD_NS) < 1 ? 1 : \
   ((1000 / `BUS_RATE_MHZ) / `CLK_PERIOD_NS))

`endif

// ===== pkg/seq_io_pkg.sv
package seq_io_pkg;

  // Access sequencer states, Gray coded along idle, stall, done
  typedef enum logic [1:0] {
    st_idle = 2'b00,
    st_stall = 2'b01,
    st_done = 2'b11
  } access_state_type;

  // What a stall is waiting for
  typedef enum logic [2:0] {
    ev_count = 3'h0,
    ev_bus_trig = 3'h1,
    ev_trig_in1 = 3'h2,
    ev_trig_in2 = 3'h3,
    ev_playback = 3'h4
  } stall_cause_type;

endpackage : seq_io_pkg

// ===== pkg/prbs_ctrl_if.sv
`timescale 1ns/1ns
// Control and result signals between the top and the marker generator
interface prbs_ctrl_if;
  logic [31:0] poly; // Characteristic polynomial
  logic [31:0] seed; // State loaded on load
  logic load; // Load seed, one cycle
  logic step; // Advance one sample, one cycle
  logic [31:0] state; // Present shift state
  logic bit_out; // Last shifted-out bit

  modport ctrl (output poly, output seed, output load, output step,
    input state, input bit_out);
  modport gen (input poly, input seed, input load, input step,
    output state, output bit_out);
endinterface : prbs_ctrl_if

// ===== rtl/prbs_marker_gen.sv
`timescale 1ns/1ns
`include "seq_io_cfg.svh"
module prbs_marker_gen (
  input wire logic ref_clk,
  input wire logic rst_b,
  prbs_ctrl_if.gen ctl
);
  // Galois shift register, one step per output sample
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctl.state <= `RST_LFSR_STATE;
      ctl.bit_out <= 1'b0;
    end else if (ctl.load) begin
      ctl.state <= ctl.seed;
      ctl.bit_out <= 1'b0;
    end else if (ctl.step) begin
      // Shift right, fold polynomial in when a one drops out
      ctl.state <= (ctl.state >> 1) ^
        (ctl.state[0] ? ctl.poly : 32'h0000_0000); // see [RULE_16]
      ctl.bit_out <= ctl.state[0]; // see [RULE_16]
    end
  end
endmodule : prbs_marker_gen

// ===== rtl/bus_strobe_detect.sv
`timescale 1ns/1ns
module bus_strobe_detect #(
  parameter int WIDTH = 32
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [WIDTH-1:0] bus_word,
  input wire logic [$clog2(WIDTH)-1:0] strobe_idx,
  input wire logic falling,
  output logic fire,
  output logic [WIDTH-1:0] latched
);
  logic prev_strobe; // Strobe level one cycle back
  logic cur_strobe; // Selected strobe bit now
  logic armed; // Strobe history valid since reset

  // Pick the strobe line
  assign cur_strobe = bus_word[strobe_idx];

  // Edge of the configured polarity, none until history is valid
  assign fire = armed &
    (falling ? (prev_strobe & ~cur_strobe)
             : (~prev_strobe & cur_strobe)); // see [RULE_09]

  // Remember last strobe level
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prev_strobe <= 1'b0;
      armed <= 1'b0;
    end else begin
      prev_strobe <= cur_strobe;
      armed <= 1'b1;
    end
  end

  // Capture the whole word at each trigger
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      latched <= '0;
    end else if (fire) begin
      latched <= bus_word; // see [RULE_07]
    end
  end
endmodule : bus_strobe_detect

// ===== rtl/sequencer_io_timing_unit.sv
// Operation
// [RULE_01] Wait lasts count plus two cycles
// [RULE_02] Wait never shorter than three cycles
// [RULE_03] Bus write drives full 32-bit word
// [RULE_04] Bus output updates paced at 50 MHz
// [RULE_05] Controller sets bus direction before writing
// [RULE_06] Bus read returns present sampled word
// [RULE_07] Latch bus word at each trigger
// [RULE_08] Trigger write sets four output lines
// [RULE_09] Bus trigger wait on strobe edge
// [RULE_10] Trigger input read returns one level
// [RULE_11] Playback wait until waveform completes
// [RULE_12] Marker carries LFSR bits, analog zero
// [RULE_13] LFSR polynomial up to 32 bits
// [RULE_14] Controller loads nonzero LFSR seed
// [RULE_15] Trigger wait on input one or two
// [RULE_16] Shift right, XOR polynomial, output bit
//
// The placing of the registers and the Avalon-MM interface to the registers were left to the implementer.
`timescale 1ns/1ns
`include "seq_io_cfg.svh"
module sequencer_io_timing_unit #(
  parameter int BUS_WIDTH = 32,
  parameter int TRIG_OUTS = 4
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire logic [BUS_WIDTH-1:0] bus_in,
  output logic [BUS_WIDTH-1:0] bus_out,
  output logic [BUS_WIDTH-1:0] bus_oe,
  output logic [TRIG_OUTS-1:0] trig_out,
  input wire logic [1:0] trig_in,
  input wire logic wave_playing,
  input wire logic sample_strobe,
  input wire logic [15:0] sample_in,
  output logic [15:0] sample_out,
  output logic [1:0] marker
);
  localparam int SEQ_CLKS = `SEQ_CYCLE_CLKS;
  localparam int PACE_CLKS = `BUS_PACE_CLKS;
  localparam int PACE_W = (PACE_CLKS > 1) ? $clog2(PACE_CLKS) : 1;

  seq_io_pkg::access_state_type state; // Access sequencer state
  seq_io_pkg::stall_cause_type cause; // Reason for present stall
  logic [39:0] stall_cnt; // Clocks left in a counted stall
  logic [39:0] next_stall_cnt; // Load value for a counted stall
  logic [33:0] wait_seq; // Requested wait in sequencer cycles
  logic req; // Any request on the bus
  logic wr_now; // Write takes effect this edge
  logic [31:0] wmask; // Byte-enable bit mask
  logic [31:0] merged; // Write data merged by byte lanes
  logic [5:0] strobe_cfg; // Strobe index and slope
  logic [2:0] marker_cfg; // Marker select and enable
  logic [31:0] lfsr_poly; // Polynomial register
  logic [31:0] bus_word; // Word waiting to go on the bus
  logic bus_pending; // Word not yet put on the bus
  logic [PACE_W-1:0] pace_cnt; // Bus update pacing counter
  logic pace_tick; // Bus may update this cycle
  logic [1:0] trig_prev; // Trigger inputs one cycle back
  logic [1:0] trig_rise; // Rising edge per trigger input
  logic trig_armed; // Edge history valid since reset
  logic bus_fire; // Bus trigger event
  logic [BUS_WIDTH-1:0] bus_latched; // Word caught at bus trigger
  logic stall_end; // Stall condition met
  logic [31:0] next_readdata; // Read value chosen at decode
  logic lfsr_load; // Seed load strobe
  logic [31:0] lfsr_seed; // Seed value

  prbs_ctrl_if prbs ();

  // Bus trigger edge detect and capture
  bus_strobe_detect #(
    .WIDTH(BUS_WIDTH)
  ) u_strobe (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .bus_word(bus_in),
    .strobe_idx(strobe_cfg[`STROBE_IDX_MSB:`STROBE_IDX_LSB]),
    .falling(strobe_cfg[`STROBE_SLOPE_BIT]),
    .fire(bus_fire),
    .latched(bus_latched)
  );

  // Marker pattern generator
  prbs_marker_gen u_prbs (
    .ref_clk(ref_clk),
    .rst_b(rst_b),
    .ctl(prbs.gen)
  );

  // Hook the generator up
  assign prbs.poly = lfsr_poly; // see [RULE_13]
  assign prbs.seed = lfsr_seed; // see [RULE_14]
  assign prbs.load = lfsr_load;
  assign prbs.step = sample_strobe & marker_cfg[`MARKER_EN_BIT];

  // Request decode
  assign req = read | write;
  // Writes land on the answer edge, together with the master's sample
  assign wr_now = write & (state == seq_io_pkg::st_done);
  // Combinational, so the answer needs no extra register stage
  assign waitrequest = req & (state != seq_io_pkg::st_done);

  // Byte-lane merge against a zero base
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      wmask[8*i +: 8] = {8{byteenable[i]}};
    end
    merged = writedata & wmask;
  end

  // Requested wait with overhead and floor, in clocks
  always_comb begin
    // Wide enough that the largest count plus overhead cannot wrap
    wait_seq = {2'h0, merged} + 34'(`WAIT_OVERHEAD); // see [RULE_01]
    if (wait_seq < 34'(`WAIT_MIN)) begin
      wait_seq = 34'(`WAIT_MIN); // see [RULE_02]
    end
    // Idle cycle and the stall cycle that sees a zero count each count one clock of the stall
    next_stall_cnt = 40'(wait_seq) * 40'(SEQ_CLKS) - 40'h2;
  end

  // Condition that ends a counted or event stall
  always_comb begin
    case (cause)
      seq_io_pkg::ev_count: stall_end = (stall_cnt == 40'h0);
      seq_io_pkg::ev_bus_trig: stall_end = bus_fire; // see [RULE_09]
      seq_io_pkg::ev_trig_in1: stall_end = trig_rise[0]; // see [RULE_15]
      seq_io_pkg::ev_trig_in2: stall_end = trig_rise[1]; // see [RULE_15]
      seq_io_pkg::ev_playback: stall_end = ~wave_playing; // see [RULE_11]
      default: stall_end = 1'b1;
    endcase
  end

  // Access sequencer: idle decode, stall, one answer cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= seq_io_pkg::st_idle;
    end else begin
      case (state)
        seq_io_pkg::st_idle: begin
          if (write && address == `OFS_WAIT_CYCLES) begin
            state <= seq_io_pkg::st_stall;
          end else if (write && address == `OFS_WAIT_CMD &&
                       merged[3:0] != 4'h0) begin
            state <= seq_io_pkg::st_stall;
          end else if (req) begin
            state <= seq_io_pkg::st_done;
          end
        end
        seq_io_pkg::st_stall: begin
          if (stall_end) begin
            state <= seq_io_pkg::st_done;
          end
        end
        seq_io_pkg::st_done: begin
          state <= seq_io_pkg::st_idle;
        end
        default: begin
          state <= seq_io_pkg::st_idle;
        end
      endcase
    end
  end

  // Stall cause and count
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      cause <= seq_io_pkg::ev_count;
      stall_cnt <= 40'h0;
    end else if (state == seq_io_pkg::st_idle && write) begin
      // Lowest command bit wins when several are set
      if (address == `OFS_WAIT_CYCLES) begin
        cause <= seq_io_pkg::ev_count;
        stall_cnt <= next_stall_cnt; // see [RULE_01]
      end else if (merged[`CMD_BUS_TRIG_BIT]) begin
        cause <= seq_io_pkg::ev_bus_trig;
      end else if (merged[`CMD_TRIG_IN1_BIT]) begin
        cause <= seq_io_pkg::ev_trig_in1;
      end else if (merged[`CMD_TRIG_IN2_BIT]) begin
        cause <= seq_io_pkg::ev_trig_in2;
      end else begin
        cause <= seq_io_pkg::ev_playback;
      end
    end else if (state == seq_io_pkg::st_stall && stall_cnt != 40'h0) begin
      // Count down the counted stall
      stall_cnt <= stall_cnt - 40'h1;
    end
  end

  // Digital trigger input edges; no edge until history is valid, so a
  // line held high across reset does not look like a fresh trigger
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_prev <= 2'h0;
      trig_armed <= 1'b0;
    end else begin
      trig_prev <= trig_in;
      trig_armed <= 1'b1;
    end
  end
  // Rising edge per input, masked in the first cycle after reset
  assign trig_rise = trig_in & ~trig_prev & {2{trig_armed}}; // see [RULE_15]

  // Read data select
  always_comb begin
    case (address)
      `OFS_BUS_READ: next_readdata = 32'(bus_in); // see [RULE_06]
      `OFS_BUS_LATCHED: next_readdata = 32'(bus_latched); // see [RULE_07]
      `OFS_BUS_WRITE: next_readdata = 32'(bus_word);
      `OFS_TRIG_OUT: next_readdata = 32'(trig_out);
      `OFS_TRIG_IN1: next_readdata = {31'h0, trig_in[0]}; // see [RULE_10]
      `OFS_TRIG_IN2: next_readdata = {31'h0, trig_in[1]}; // see [RULE_10]
      `OFS_STROBE_CFG: next_readdata = {26'h0, strobe_cfg};
      `OFS_STATUS: next_readdata = {27'h0, wave_playing, trig_in,
                                     bus_pending, marker[0]};
      `OFS_LFSR_POLY: next_readdata = lfsr_poly;
      `OFS_LFSR_STATE: next_readdata = prbs.state;
      `OFS_MARKER_CFG: next_readdata = {29'h0, marker_cfg};
      `OFS_BUS_DIR: next_readdata = 32'(bus_oe);
      default: next_readdata = 32'h0;
    endcase
  end

  // Read data stands during the answer cycle
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      readdata <= 32'h0;
    end else if (state == seq_io_pkg::st_idle && read) begin
      readdata <= next_readdata;
    end
  end

  // Bus direction, set by the controller before bus writes
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_oe <= '0;
    end else if (wr_now && address == `OFS_BUS_DIR) begin
      bus_oe <= BUS_WIDTH'(merged); // see [RULE_05]
    end
  end

  // Word queued for the bus
  // A new write wins over the pace tick that clears the flag
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_word <= 32'h0;
      bus_pending <= 1'b0;
    end else if (wr_now && address == `OFS_BUS_WRITE) begin
      bus_word <= merged; // see [RULE_03]
      bus_pending <= 1'b1;
    end else if (pace_tick) begin
      bus_pending <= 1'b0;
    end
  end

  // Pacing counter for bus updates
  // With the bus rate equal to ref_clk the counter stays at zero
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      pace_cnt <= '0;
    end else if (pace_cnt == PACE_W'(PACE_CLKS - 1)) begin
      pace_cnt <= '0;
    end else begin
      pace_cnt <= pace_cnt + PACE_W'(1);
    end
  end
  assign pace_tick = (pace_cnt == PACE_W'(PACE_CLKS - 1));

  // Drive the bus only on pace ticks
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      bus_out <= '0;
    end else if (pace_tick && bus_pending) begin
      bus_out <= BUS_WIDTH'(bus_word); // see [RULE_04]
    end
  end

  // Trigger output lines, all four at once
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      trig_out <= '0;
    end else if (wr_now && address == `OFS_TRIG_OUT) begin
      trig_out <= TRIG_OUTS'(merged); // see [RULE_08]
    end
  end

  // Strobe configuration
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      strobe_cfg <= `RST_STROBE_CFG;
    end else if (wr_now && address == `OFS_STROBE_CFG) begin
      strobe_cfg <= merged[5:0];
    end
  end

  // Polynomial and marker configuration
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lfsr_poly <= `RST_LFSR_POLY;
      marker_cfg <= `RST_MARKER_CFG;
    end else if (wr_now && address == `OFS_LFSR_POLY) begin
      lfsr_poly <= merged; // see [RULE_13]
    end else if (wr_now && address == `OFS_MARKER_CFG) begin
      marker_cfg <= merged[2:0];
    end
  end

  // Seed load strobe
  // Load trails the write by a clock so the seed register is settled
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      lfsr_load <= 1'b0;
      lfsr_seed <= `RST_LFSR_STATE;
    end else begin
      lfsr_load <= wr_now && address == `OFS_LFSR_STATE;
      if (wr_now && address == `OFS_LFSR_STATE) begin
        lfsr_seed <= merged;
      end
    end
  end

  // Sample and marker outputs
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      sample_out <= 16'h0000;
      marker <= 2'h0;
    end else if (marker_cfg[`MARKER_EN_BIT]) begin
      sample_out <= 16'h0000; // see [RULE_12]
      marker[0] <= (marker_cfg[1:0] == 2'h1) & prbs.bit_out; // see [RULE_12]
      marker[1] <= (marker_cfg[1:0] == 2'h2) & prbs.bit_out; // see [RULE_12]
    end else begin
      sample_out <= sample_in;
      marker <= 2'h0;
    end
  end
endmodule : sequencer_io_timing_unit

// ===== test/seq_io_properties.sv
`timescale 1ns/1ns
module seq_io_properties (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] writedata,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  input wire logic [31:0] bus_in,
  input wire logic [31:0] bus_out,
  input wire logic [3:0] trig_out,
  input wire logic [1:0] trig_in,
  input wire logic wave_playing
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rst_b);
  logic [31:0] stall_cnt; // Busy cycles of a wait write
  // Count busy cycles while a wait write is pending
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      stall_cnt <= 32'h0;
    end else if (write && address == 8'h00 && waitrequest) begin
      stall_cnt <= stall_cnt + 32'h1;
    end else begin
      // Start afresh after each answer, even back to back
      stall_cnt <= 32'h0;
    end
  end
  property p_wait_len;
    write && !waitrequest && address == 8'h00 && byteenable == 4'hf |->
      stall_cnt == (writedata < 32'h2 ? 32'h3 : writedata + 32'h2);
  endproperty
  a_wait_len: assert property (p_wait_len)
    else $error("wait stall length wrong");
  property p_bus_write;
    write && !waitrequest && address == 8'h04 && byteenable == 4'hf
      |-> ##2 bus_out == $past(writedata, 2);
  endproperty
  a_bus_write: assert property (p_bus_write)
    else $error("bus word not driven");
  property p_bus_pace;
    $changed(bus_out) |-> $past(write && !waitrequest && address == 8'h04, 2);
  endproperty
  a_bus_pace: assert property (p_bus_pace)
    else $error("bus word changed without paced write");
  property p_bus_read;
    read && !waitrequest && address == 8'h08 && $stable(bus_in) &&
      bus_in == $past(bus_in, 2) |-> readdata == bus_in;
  endproperty
  a_bus_read: assert property (p_bus_read)
    else $error("live bus read wrong");
  property p_trig_write;
    write && !waitrequest && address == 8'h10 && byteenable[0]
      |=> trig_out == $past(writedata[3:0]);
  endproperty
  a_trig_write: assert property (p_trig_write)
    else $error("trigger lines wrong");
  property p_trig_read;
    read && !waitrequest && (address == 8'h14 || address == 8'h18) &&
      $stable(trig_in) && trig_in == $past(trig_in, 2) |->
      readdata == {31'h0, address[3] ? trig_in[1] : trig_in[0]};
  endproperty
  a_trig_read: assert property (p_trig_read)
    else $error("trigger input read wrong");
  property p_play_wait;
    write && waitrequest && address == 8'h20 && writedata[3:0] == 4'h8
      && !wave_playing |-> ##[0:2] !waitrequest;
  endproperty
  a_play_wait: assert property (p_play_wait)
    else $error("playback wait did not end");
  property p_trig_wait;
    write && waitrequest && address == 8'h20 && writedata[3:0] == 4'h2
      && $rose(trig_in[0]) |-> ##[0:2] !waitrequest;
  endproperty
  a_trig_wait: assert property (p_trig_wait)
    else $error("trigger wait did not end");
endmodule : seq_io_properties
bind sequencer_io_timing_unit seq_io_properties u_seq_io_properties (
  .ref_clk(ref_clk), .rst_b(rst_b), .address(address), .read(read),
  .write(write), .byteenable(byteenable), .writedata(writedata),
  .readdata(readdata), .waitrequest(waitrequest), .bus_in(bus_in),
  .bus_out(bus_out), .trig_out(trig_out), .trig_in(trig_in),
  .wave_playing(wave_playing));

// ===== test/bus_far_end.sv
`timescale 1ns/1ns
// Far equipment on the parallel bus
module bus_far_end (
  input wire logic [31:0] bus_out,
  input wire logic [31:0] bus_oe,
  input wire logic [31:0] ext_word,
  output logic [31:0] bus_in
);
  // Equipment drives only lines the device leaves as inputs
  assign bus_in = (bus_out & bus_oe) | (ext_word & ~bus_oe);
endmodule : bus_far_end

// ===== test/test_sequencer_io_timing_unit.sv
`timescale 1ns/1ns
module test_sequencer_io_timing_unit;
  // Access row: direction, address, data, expected result
  typedef struct {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] e;
  } row_type;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [3:0] byteenable = 4'hf;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, bus_in, bus_out, bus_oe;
  logic [31:0] ext_word = 32'h0; // Equipment word
  logic waitrequest;
  logic [3:0] trig_out;
  logic [1:0] trig_in = 2'b00;
  logic wave_playing = 1'b0;
  logic sample_strobe = 1'b0;
  logic [15:0] sample_in = 16'h7fff;
  logic [15:0] sample_out;
  logic [1:0] marker;
  int fails = 0;
  int checks = 0;
  int cyc = 0;
  int n;
  logic [31:0] q;
  logic [31:0] s; // Shift register model
  logic b;
  logic [31:0] pl [2] = '{32'h0009_0000, 32'h8000_0057};
  logic [31:0] sd [2] = '{32'h1, 32'h0001_2345};
  row_type rows [16] = '{
    '{1'b0, 8'h28, 32'h0, 32'h0009_0000}, '{1'b0, 8'h2c, 32'h0, 32'h1},
    '{1'b0, 8'h30, 32'h0, 32'h1}, '{1'b0, 8'h1c, 32'h0, 32'h0},
    '{1'b1, 8'h00, 32'h0, 32'h3}, '{1'b1, 8'h00, 32'h1, 32'h3},
    '{1'b1, 8'h00, 32'h2, 32'h4}, '{1'b1, 8'h00, 32'h3, 32'h5},
    '{1'b1, 8'h00, 32'h28, 32'h2a}, '{1'b1, 8'h34, 32'hffff_ffff, 32'h1},
    '{1'b1, 8'h04, 32'ha5c3_0f1e, 32'h1}, '{1'b0, 8'h04, 32'h0, 32'ha5c3_0f1e},
    '{1'b0, 8'h08, 32'h0, 32'ha5c3_0f1e}, '{1'b1, 8'h10, 32'ha, 32'h1},
    '{1'b0, 8'h10, 32'h0, 32'ha}, '{1'b0, 8'h40, 32'h0, 32'h0}};
  sequencer_io_timing_unit u_sequencer_io_timing_unit (
    .ref_clk(ref_clk), .rst_b(rst_b), .address(address), .read(read),
    .write(write), .byteenable(byteenable), .writedata(writedata),
    .readdata(readdata), .waitrequest(waitrequest), .bus_in(bus_in),
    .bus_out(bus_out), .bus_oe(bus_oe), .trig_out(trig_out),
    .trig_in(trig_in), .wave_playing(wave_playing),
    .sample_strobe(sample_strobe), .sample_in(sample_in),
    .sample_out(sample_out), .marker(marker));
  bus_far_end u_bus_far_end (.bus_out(bus_out), .bus_oe(bus_oe),
    .ext_word(ext_word), .bus_in(bus_in));
  // Clock generator
  initial begin
    forever #10 ref_clk = ~ref_clk;
  end
  // Verdict and end of run
  task automatic end_of_test();
    if (fails == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : end_of_test
  // Hang guard
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      end_of_test();
    end
  end
  // Compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp) begin
      fails++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask : chk
  // One bus access; k counts rising edges up to the answer
  task automatic acc(input logic w, input logic [7:0] a,
      input logic [31:0] d, output int k, output logic [31:0] r);
    k = 0;
    @(posedge ref_clk);
    address <= a;
    writedata <= d;
    write <= w;
    read <= !w;
    // Hold until waitrequest is sampled low at a rising edge
    do begin
      @(posedge ref_clk);
      k++;
    end while (waitrequest !== 1'b0);
    r = readdata;
    write <= 1'b0;
    read <= 1'b0;
  endtask : acc
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    acc(1'b1, a, d, n, q);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [31:0] e);
    acc(1'b0, a, 32'h0, n, q);
    chk(q, e);
  endtask : rd
  // Event wait; the event lands dly-1 edges after the request goes out
  task automatic stall(input logic [3:0] c, input int dly,
      input logic [34:0] v);
    fork
      acc(1'b1, 8'h20, {28'h0, c}, n, q);
      begin
        repeat (dly) @(posedge ref_clk);
        {ext_word, trig_in, wave_playing} <= v;
      end
    join
    chk(32'(n - 1), 32'(dly));
  endtask : stall
  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk);
    rst_b <= 1'b1;
    foreach (rows[i]) begin
      acc(rows[i].w, rows[i].a, rows[i].d, n, q);
      chk(rows[i].w ? 32'(n - 1) : q, rows[i].e);
    end
    chk(bus_out, 32'ha5c3_0f1e);
    chk(bus_oe, 32'hffff_ffff);
    chk(32'(trig_out), 32'ha);
    wr(8'h34, 32'h0);
    wr(8'h1c, 32'h5);
    ext_word <= 32'h1234_5600;
    stall(4'h1, 6, {32'h1234_5660, 3'b000});
    rd(8'h0c, 32'h1234_5660);
    wr(8'h1c, 32'h25);
    stall(4'h1, 6, {32'h0bad_f00d, 3'b000});
    rd(8'h0c, 32'h0bad_f00d);
    rd(8'h08, 32'h0bad_f00d);
    stall(4'h2, 6, {32'h0bad_f00d, 3'b010});
    stall(4'h4, 6, {32'h0bad_f00d, 3'b110});
    {trig_in, wave_playing} <= 3'b101;
    rd(8'h14, 32'h0);
    rd(8'h18, 32'h1);
    rd(8'h24, 32'h18);
    stall(4'h8, 9, {32'h0bad_f00d, 3'b100});
    for (int j = 0; j < 2; j++) begin
      wr(8'h28, pl[j]);
      wr(8'h2c, sd[j]);
      wr(8'h30, 32'h5 + 32'(j));
      s = sd[j];
      for (int k = 0; k < 8; k++) begin
        @(posedge ref_clk);
        sample_strobe <= 1'b1;
        @(posedge ref_clk);
        sample_strobe <= 1'b0;
        b = s[0];
        s = (s >> 1) ^ (b ? pl[j] : 32'h0);
        repeat (2) @(negedge ref_clk);
        chk(32'(marker), 32'(j ? {b, 1'b0} : {1'b0, b}));
        chk(32'(sample_out), 32'h0);
      end
      rd(8'h2c, s);
    end
    @(posedge ref_clk);
    rst_b <= 1'b0;
    repeat (2) @(negedge ref_clk);
    chk(32'(trig_out), 32'h0);
    chk(32'(marker), 32'h0);
    @(posedge ref_clk);
    rst_b <= 1'b1;
    rd(8'h10, 32'h0);
    rd(8'h2c, 32'h1);
    rd(8'h0c, 32'h0);
    chk(32'(sample_out), 32'h7fff);
    byteenable <= 4'h5;
    wr(8'h04, 32'hffff_ffff);
    byteenable <= 4'hf;
    rd(8'h04, 32'h00ff_00ff);
    end_of_test();
  end
endmodule : test_sequencer_io_timing_unit
